// ==== src/handshake_cfg.svh ====
/*
  constants for the host-link wake and attention handshake: timing, widths, address.
  assumes a 50 MHz mclk; included by bare name wherever the numbers are needed.
*/
// Operation
// R1: link carries optional host request input and device attention output beside I2C.
// R2: low-battery mode ignores request; attention only for host-started exchanges.
// R3: low-battery mode never reports secure-module activity to the host.
// R4: in low-battery mode host commands proceed under SCL stretch while device wakes.
// R5: normal case: attention once for acknowledge frame, again for response frame.
// R6: awake device accepts request-opened exchange and answers with same handshake.
// R7: request wakes a sleeping device; it asserts attention once ready.
// R8: host waits wake delay, or watches attention with that timeout, before sending.
// R9: attention released when own address seen in the write transfer.
// R10: acknowledge frame always precedes the response frame.
// R11: response ready asserts attention; host reads it with addressed read.
// R12: own address at start of response read releases attention.
// R13: host holds request low 1us awake, oscillator start (to 2ms) asleep.
// R14: request fall to attention fall at most 10us awake, osc start plus 10us asleep.
// R15: without request line, device stretches SCL after own address until ready.
// R16: device needs about 1ms after response to power down; host avoids commands.
// R17: after target-init acknowledge, sleep when no RF field present.
// R18: target-init sleep ends on RF field or new host command.
// R19: activated target asserts attention for response, waking a sleeping host.
// R20: host may request before target-init, then waits for attention first.
// R21: host reaction time after attention is unbounded by the device.
// R22: attention is active low; each assertion ends by releasing the line high.
// R23: oscillator start and power-down entry delay are parameters counted in mclk cycles.
`ifndef HANDSHAKE_CFG_SVH
`define HANDSHAKE_CFG_SVH

`define CLK_PERIOD_NS  20
`define READY_MAX_NS   10000
`define READY_CYC      (`READY_MAX_NS / `CLK_PERIOD_NS)
`define OSC_START_NS   2000000
`define OSC_START_CYC  ((`OSC_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PD_ENTRY_NS    1000000
`define PD_ENTRY_CYC   ((`PD_ENTRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OWN_ADDR       7'h2a
`define RX_WIDTH       8
`define RX_FIFO_DEPTH  8
`define BYTE_BITS      4'h8
`define PIN_IDLE       3'h7

`endif

// ==== src/handshake_pkg.sv ====
/*
  types shared by the handshake block: pin carrier and state enumerations.
  assumes nothing beyond a SystemVerilog elaborator.
*/
package handshake_pkg;

  // sampled host-link pins, carried together through the synchroniser
  typedef struct packed {
    logic req_n;
    logic scl;
    logic sda;
  } pin_s;

  typedef enum logic [1:0] {PWR_AWAKE, PWR_ENTERING, PWR_SLEEP, PWR_WAKING} pwr_e;

  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_DATA, I2C_HOLD, I2C_ACK, I2C_SKIP} i2c_e;

endpackage : handshake_pkg

// ==== src/i2c_host_wake_handshake.sv ====
/*
  device-side wake and attention handshake beside an I2C slave link: address spotting,
  SCL stretching, power state sequencing and the active-low attention line.
  assumes the device core pulses frame-ready events on mclk and drains received bytes;
  host-link pins are asynchronous and pass pin_sync.
*/
`include "handshake_cfg.svh"

module i2c_host_wake_handshake #(
  parameter int unsigned OSC_CYC    = `OSC_START_CYC,
  parameter int unsigned PD_CYC     = `PD_ENTRY_CYC,
  parameter logic [6:0]  OWN_ADDR   = `OWN_ADDR,
  parameter int unsigned FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // host request pin, active low
  input  wire logic                 wake_interrupt_input_n,
  // open-drain I2C pins: level in, level out, enable low while driving
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_oe_n,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n,
  // attention line to the host, active low
  output logic                      device_attention_line_n,
  // device core events and modes
  input  wire logic                 low_battery_mode,
  input  wire logic                 secure_access_module_event,
  input  wire logic                 ack_frame_ready,
  input  wire logic                 resp_frame_ready,
  input  wire logic                 power_down_req,
  input  wire logic                 target_init_ack,
  input  wire logic                 rf_field,
  output logic                      device_awake,
  // received bytes toward the core
  output logic [`RX_WIDTH-1:0]      rx_data,
  output logic                      rx_valid,
  input  wire logic                 rx_ready
);

  localparam int unsigned RDY_CYC = `READY_CYC;
  localparam int unsigned CMAX    = (OSC_CYC > PD_CYC) ? OSC_CYC : PD_CYC;
  localparam int unsigned CW      = $clog2(CMAX + 1);
  localparam int unsigned RW      = $clog2(RDY_CYC + 1);

  if (OSC_CYC < 1 || PD_CYC < 1 || RDY_CYC < 1) begin : g_chk
    $error("handshake delays must be at least one cycle");
  end

  handshake_pkg::pin_s pin_q;
  handshake_pkg::pin_s pin_d_r;
  handshake_pkg::pwr_e pwr_r;
  handshake_pkg::i2c_e i2c_r;

  logic [CW-1:0]         pwr_cnt_r;
  logic                  awake_r;
  logic [RW-1:0]         rdy_cnt_r;
  logic                  req_pend_r;
  logic                  ack_seen_r;
  logic                  resp_pend_r;
  logic                  attn_n_r;
  logic [7:0]            sh_r;
  logic [3:0]            bit_cnt_r;
  logic                  is_addr_r;
  logic                  rw_r;
  logic                  scl_oe_n_r;
  logic                  sda_oe_n_r;
  logic                  drive_low_r;
  logic                  fifo_ready;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_det;
  logic                  stop_det;
  logic                  req_fall;
  logic                  byte_end;
  logic                  addr_hit;
  logic                  hold_go;
  logic                  stall;
  logic                  push;
  logic                  req_fire;
  logic                  sec_fire;
  logic                  resp_fire;
  logic                  attn_set;
  logic                  wake_src;

  // request, SCL and SDA come from the host's domain [R1]
  pin_sync #(
    .W   ($bits(handshake_pkg::pin_s)),
    .RST (`PIN_IDLE)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      ({wake_interrupt_input_n, scl_in, sda_in}),
    .q      (pin_q)
  );

  // previous filtered levels for edge and bus-condition detection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) pin_d_r <= `PIN_IDLE;
    else         pin_d_r <= pin_q;
  end

  assign scl_rise  = pin_q.scl && !pin_d_r.scl;
  assign scl_fall  = !pin_q.scl && pin_d_r.scl;
  assign start_det = pin_q.scl && pin_d_r.scl && pin_d_r.sda && !pin_q.sda;
  assign stop_det  = pin_q.scl && pin_d_r.scl && !pin_d_r.sda && pin_q.sda;
  assign req_fall  = pin_d_r.req_n && !pin_q.req_n;

  // byte boundary: eighth bit taken, SCL just went low, so stretching is safe here
  assign byte_end = scl_fall && (bit_cnt_r == `BYTE_BITS)
                 && (i2c_r == handshake_pkg::I2C_ADDR || i2c_r == handshake_pkg::I2C_DATA);
  assign addr_hit = byte_end && (i2c_r == handshake_pkg::I2C_ADDR) && (sh_r[7:1] == OWN_ADDR);
  assign hold_go  = addr_hit || (byte_end && i2c_r == handshake_pkg::I2C_DATA);
  // address waits for a ready device, data waits for room in the FIFO
  assign stall    = is_addr_r ? !awake_r : !fifo_ready;
  assign push     = (i2c_r == handshake_pkg::I2C_HOLD) && !stall && !is_addr_r;

  // slave receiver: spots own address, acknowledges, buffers written bytes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      i2c_r     <= handshake_pkg::I2C_IDLE;
      sh_r      <= 8'h00;
      bit_cnt_r <= 4'h0;
      is_addr_r <= 1'b0;
      rw_r      <= 1'b0;
    end else if (start_det) begin
      i2c_r     <= handshake_pkg::I2C_ADDR;
      bit_cnt_r <= 4'h0;
    end else if (stop_det) begin
      i2c_r <= handshake_pkg::I2C_IDLE;
    end else begin
      unique case (i2c_r)
        handshake_pkg::I2C_IDLE, handshake_pkg::I2C_SKIP: begin
        end
        handshake_pkg::I2C_ADDR, handshake_pkg::I2C_DATA: begin
          if (scl_rise) begin
            sh_r      <= {sh_r[6:0], pin_q.sda};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (hold_go) begin
            i2c_r     <= handshake_pkg::I2C_HOLD;
            is_addr_r <= (i2c_r == handshake_pkg::I2C_ADDR);
            if (i2c_r == handshake_pkg::I2C_ADDR) rw_r <= sh_r[0];
          end else if (byte_end) begin
            i2c_r <= handshake_pkg::I2C_SKIP;   // another slave's address
          end
        end
        handshake_pkg::I2C_HOLD: begin
          if (!stall) i2c_r <= handshake_pkg::I2C_ACK;
        end
        handshake_pkg::I2C_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            // reads are only spotted; response bytes come from elsewhere
            i2c_r <= (is_addr_r && rw_r) ? handshake_pkg::I2C_SKIP : handshake_pkg::I2C_DATA;
          end
        end
        default: i2c_r <= handshake_pkg::I2C_IDLE;  // unused codes fall back to idle
      endcase
    end
  end

  // pin drives: SCL held low while stalled, SDA low through the acknowledge bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_oe_n_r  <= 1'b1;
      sda_oe_n_r  <= 1'b1;
      drive_low_r <= 1'b0;
    end else begin
      drive_low_r <= 1'b0;
      scl_oe_n_r  <= !(hold_go || (i2c_r == handshake_pkg::I2C_HOLD && stall));  // [R15] [R4]
      if (start_det || stop_det || (i2c_r == handshake_pkg::I2C_ACK && scl_fall)) begin
        sda_oe_n_r <= 1'b1;
      end else if (i2c_r == handshake_pkg::I2C_HOLD && !stall) begin
        sda_oe_n_r <= 1'b0;
      end
    end
  end

  assign scl_out  = drive_low_r;
  assign sda_out  = drive_low_r;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;

  // a full FIFO stretches SCL, so back-pressure reaches the host
  rx_fifo #(
    .WIDTH (`RX_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (sh_r),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // low-battery mode leaves the request line without effect
  assign wake_src = (req_fall && !low_battery_mode) || addr_hit || rf_field;  // [R2] [R18]

  // power sequencing; oscillator start and entry delay are cycle counts
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r     <= handshake_pkg::PWR_AWAKE;
      pwr_cnt_r <= '0;
      awake_r   <= 1'b1;
    end else begin
      unique case (pwr_r)
        handshake_pkg::PWR_AWAKE: begin
          if (power_down_req || (target_init_ack && !rf_field)) begin  // [R17]
            pwr_r     <= handshake_pkg::PWR_ENTERING;
            pwr_cnt_r <= CW'(PD_CYC - 1);  // [R16] [R23]
            awake_r   <= 1'b0;
          end
        end
        handshake_pkg::PWR_ENTERING: begin
          // still clocked, so a wake source returns at once
          if (wake_src) begin
            pwr_r   <= handshake_pkg::PWR_AWAKE;
            awake_r <= 1'b1;
          end else if (pwr_cnt_r == '0) begin
            pwr_r <= handshake_pkg::PWR_SLEEP;
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 1'b1;
          end
        end
        handshake_pkg::PWR_SLEEP: begin
          if (wake_src) begin  // [R7] [R18]
            pwr_r     <= handshake_pkg::PWR_WAKING;
            pwr_cnt_r <= CW'(OSC_CYC - 1);  // [R23]
          end
        end
        handshake_pkg::PWR_WAKING: begin
          if (pwr_cnt_r == '0) begin
            pwr_r   <= handshake_pkg::PWR_AWAKE;
            awake_r <= 1'b1;
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  assign device_awake = awake_r;

  // request handshake: attention follows the ready delay once awake
  assign req_fire = req_pend_r && awake_r && (rdy_cnt_r == RW'(RDY_CYC - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_pend_r <= 1'b0;
      rdy_cnt_r  <= '0;
    end else if (low_battery_mode) begin
      req_pend_r <= 1'b0;  // [R2]
    end else if (req_fall) begin
      req_pend_r <= 1'b1;  // [R6] [R7]
      rdy_cnt_r  <= '0;
    end else if (req_fire) begin
      req_pend_r <= 1'b0;
    end else if (req_pend_r && awake_r) begin
      rdy_cnt_r <= rdy_cnt_r + 1'b1;  // [R14]
    end
  end

  // response waits for its acknowledge and for the host to have read that
  assign resp_fire = resp_pend_r && ack_seen_r && attn_n_r && !ack_frame_ready;  // [R10]

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_seen_r  <= 1'b0;
      resp_pend_r <= 1'b0;
    end else begin
      ack_seen_r  <= ack_frame_ready || (ack_seen_r && !resp_fire);
      resp_pend_r <= resp_frame_ready || (resp_pend_r && !resp_fire);
    end
  end

  // secure-module events are silent in low-battery mode
  assign sec_fire = secure_access_module_event && !low_battery_mode;  // [R3]
  assign attn_set = req_fire || sec_fire || ack_frame_ready || resp_fire;  // [R5] [R11] [R19]

  // attention: an assertion outranks a release in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      attn_n_r <= 1'b1;
    end else if (attn_set) begin
      attn_n_r <= 1'b0;  // [R22]
    end else if (addr_hit) begin
      attn_n_r <= 1'b1;  // [R9] [R12]
    end
  end

  assign device_attention_line_n = attn_n_r;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  attn_release_a: assert property (addr_hit && !attn_set |=> device_attention_line_n) // [R9]
    else $error("attention not released after own address");
  read_release_a: assert property (addr_hit && sh_r[0] && !attn_set |=> attn_n_r && rw_r) // [R12]
    else $error("attention not released on response read address");
  lowbat_ignore_a: assert property (low_battery_mode |=> !req_pend_r) // [R2]
    else $error("request honoured in low-battery mode");
  secure_silent_a: assert property (low_battery_mode && secure_access_module_event
                                    && attn_n_r && !req_fire && !ack_frame_ready && !resp_fire
                                    |=> attn_n_r) // [R3]
    else $error("secure-module event signalled in low-battery mode");
  secure_attn_a: assert property (secure_access_module_event && !low_battery_mode
                                  |=> !device_attention_line_n) // [R3]
    else $error("secure-module event not signalled outside low-battery mode");
  stretch_sleep_a: assert property (i2c_r == handshake_pkg::I2C_HOLD && is_addr_r && !awake_r
                                    |=> !scl_oe_n) // [R15]
    else $error("SCL not stretched while device not ready");
  wake_req_a: assert property (pwr_r == handshake_pkg::PWR_SLEEP && req_fall && !low_battery_mode
                               |=> pwr_r == handshake_pkg::PWR_WAKING) // [R7]
    else $error("request did not start wake-up");
  ready_time_a: assert property (req_fall && awake_r && !low_battery_mode && !power_down_req
                                 && !target_init_ack |-> ##[1:510] !device_attention_line_n) // [R14]
    else $error("attention late after request");
  ack_first_a: assert property ($fell(attn_n_r) && $past(resp_fire) |-> $past(ack_seen_r)) // [R10]
    else $error("response signalled before acknowledge");
  resp_attn_a: assert property (resp_fire |=> !device_attention_line_n ##1 !ack_seen_r
                                || $past(ack_frame_ready)) // [R11]
    else $error("response ready without attention");
  ack_attn_a: assert property (ack_frame_ready |=> !device_attention_line_n) // [R5]
    else $error("acknowledge ready without attention");
  tg_sleep_a: assert property (pwr_r == handshake_pkg::PWR_AWAKE && target_init_ack && !rf_field
                               |=> pwr_r == handshake_pkg::PWR_ENTERING && !device_awake) // [R17]
    else $error("target-init acknowledge did not start power down");
  rf_wake_a: assert property (pwr_r == handshake_pkg::PWR_SLEEP && rf_field
                              |=> pwr_r == handshake_pkg::PWR_WAKING) // [R18]
    else $error("RF field did not wake device");

  wake_seq_c: cover property (pwr_r == handshake_pkg::PWR_WAKING ##1 awake_r ##[1:600] req_fire);
  addr_hit_c: cover property (addr_hit && !sh_r[0]);
  fifo_full_c: cover property (i2c_r == handshake_pkg::I2C_HOLD && !is_addr_r && !fifo_ready);
  resp_c: cover property (resp_fire ##[1:1000] addr_hit && sh_r[0]);
  lowbat_req_c: cover property (low_battery_mode && req_fall);

endmodule : i2c_host_wake_handshake

// ==== src/pin_sync.sv ====
/*
  three-stage synchroniser with agreement filter for asynchronous pins.
  assumes inputs are unrelated to mclk; output changes only once stages two and three agree.
*/
module pin_sync #(
  parameter int unsigned  W   = 3,
  parameter logic [W-1:0] RST = '1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         arst_n,
  // pins in, filtered levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // first stage feeds only the second; filter looks at stages two and three
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        s1_r[i] <= RST[i];
        s2_r[i] <= RST[i];
        s3_r[i] <= RST[i];
        q[i]    <= RST[i];
      end else begin
        s1_r[i] <= d[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) q[i] <= s3_r[i];
      end
    end
  end

endmodule : pin_sync

// ==== src/rx_fifo.sv ====
/*
  receive byte FIFO with a registered output stage; valid/ready on both sides.
  assumes DEPTH is a power of two; holds DEPTH words in memory plus one in the output stage.
*/
module rx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("rx_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             wr;
  logic             rd;

  // full stalls the filler; output stage reloads whenever empty or consumed
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign wr       = in_valid && in_ready;
  assign rd       = (count_r != '0) && (!out_valid || out_ready);

  // storage and pointers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (wr) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (rd) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  always_ff @(posedge mclk) begin
    if (wr) mem[wr_ptr_r] <= in_data;
  end

  // registered output stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (rd) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : rx_fifo

// ==== verif/host_model.sv ====
/*
  host controller model acting as I2C master with an optional request line.
  assumes pull-ups on SCL and SDA; the device pulls through its active-low enables.
*/
module host_model (
  // device pulls, enable low while pulling
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  // resolved wires and request pin
  output logic      scl,
  output logic      sda,
  output logic      req_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_low;
  logic sda_low;

  // pull-ups: a released wire rises unless some party pulls it low
  assign scl = ~(scl_low | ~scl_oe_n);
  assign sda = ~(sda_low | ~sda_oe_n);

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    req_n   = 1'b1;
  end

  // one clock pulse; a stretched clock is waited out, bounded at 2 ms
  task automatic pulse(output logic s);
    int n;
    n = 0;
    #60 scl_low = 1'b0;
    while (scl !== 1'b1 && n < 100000) begin
      #20 n++;
    end
    #40 s = sda;
    #40 scl_low = 1'b1;
  endtask : pulse

  task automatic start();
    #80 sda_low = 1'b1;
    #80 scl_low = 1'b1;
  endtask : start

  task automatic stop();
    #20 sda_low = 1'b1;
    #80 scl_low = 1'b0;
    #80 sda_low = 1'b0;
    #80;
  endtask : stop

  // msb first; extra low time before the ack so the device can hold the clock
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      #20 sda_low = ~b[i];
      pulse(s);
    end
    #20 sda_low = 1'b0;
    #160;
    pulse(ack);
  endtask : put_byte

  // request pulse of cyc mclk periods, then req_n released; this model has no attention input
  task automatic req(input int cyc);
    req_n = 1'b0;
    #(cyc * 20) req_n = 1'b1;
  endtask : req
endmodule : host_model

// ==== verif/testbench.sv ====
/*
  self-checking bench for the wake and attention handshake.
  assumes short wake counts (OSC_CYC 20, PD_CYC 30) and the host model as far side.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, scl, sda, req_n, lowbat, sec_evt, ackr, respr, pdr, tia, rf, rx_ready;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, att_n, awake, rx_valid;
  logic [7:0] rx_data;
  logic [7:0] got_q[$];
  int n_fail, samples_checked, cyc;

  i2c_host_wake_handshake #(.OSC_CYC(20), .PD_CYC(30)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .wake_interrupt_input_n(req_n),
    .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .device_attention_line_n(att_n), .low_battery_mode(lowbat),
    .secure_access_module_event(sec_evt),
    .ack_frame_ready(ackr), .resp_frame_ready(respr), .power_down_req(pdr),
    .target_init_ack(tia), .rf_field(rf), .device_awake(awake),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
  host_model host_u (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda),
    .req_n(req_n));

  // clock, and received bytes logged as the core takes them
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rx_valid && rx_ready) got_q.push_back(rx_data);
  end

  // hang guard: far above the few thousand cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_att(input logic exp, input int max);
    int n;
    n = 0;
    while (att_n !== exp && n < max) begin
      @(negedge mclk);
      n++;
    end
    check(att_n, exp);
  endtask : wait_att

  task automatic fire(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : fire

  // addressed transfer; a write carries nb data bytes from 8'h5a up
  task automatic xfer(input logic rd, input int nb);
    logic a;
    host_u.start();
    host_u.put_byte({7'h2a, rd}, a);
    check(a, 1'b0);
    for (int i = 0; i < nb; i++) begin
      host_u.put_byte(8'h5a + 8'(i), a);
      check(a, 1'b0);
    end
    host_u.stop();
    repeat (8) @(negedge mclk);
  endtask : xfer

  task automatic s_normal();
    xfer(1'b0, 1);
    check(got_q.pop_front(), 8'h5a);
    fire(ackr);
    wait_att(1'b0, 3);
    xfer(1'b1, 0);
    wait_att(1'b1, 2);
    fire(respr);
    wait_att(1'b0, 3);
    xfer(1'b1, 0);
    wait_att(1'b1, 2);
  endtask : s_normal

  // ready delay after a request is 500 cycles plus sync latency
  task automatic s_req_awake();
    host_u.req(50);
    repeat (440) @(negedge mclk);
    check(att_n, 1'b1);
    wait_att(1'b0, 30);
    xfer(1'b0, 1);
    check(att_n, 1'b1);
    check(got_q.pop_front(), 8'h5a);
  endtask : s_req_awake

  task automatic s_sleep();
    fire(pdr);
    @(negedge mclk);
    check(awake, 1'b0);
    repeat (40) @(negedge mclk);
    host_u.req(30);
    wait_att(1'b0, 560);
    check(awake, 1'b1);
    xfer(1'b0, 1);
    fire(pdr);
    repeat (40) @(negedge mclk);
    xfer(1'b0, 1);
    check(awake, 1'b1);
    check(8'(got_q.size()), 8'h02);
    got_q.delete();
  endtask : s_sleep

  task automatic s_lowbat();
    lowbat = 1'b1;
    host_u.req(50);
    fire(sec_evt);
    repeat (600) @(negedge mclk);
    check(att_n, 1'b1);
    lowbat = 1'b0;
    // outside low-battery mode the same event must raise attention
    fire(sec_evt);
    wait_att(1'b0, 3);
    xfer(1'b1, 0);
    wait_att(1'b1, 2);
  endtask : s_lowbat

  task automatic s_target();
    fire(ackr);
    wait_att(1'b0, 3);
    xfer(1'b1, 0);
    fire(tia);
    @(negedge mclk);
    check(awake, 1'b0);
    repeat (40) @(negedge mclk);
    rf = 1'b1;
    repeat (30) @(negedge mclk);
    check(awake, 1'b1);
    fire(respr);
    wait_att(1'b0, 3);
    xfer(1'b1, 0);
    wait_att(1'b1, 2);
    rf = 1'b0;
  endtask : s_target

  // 8 words plus the output stage fill, then the clock is held until drained
  task automatic s_fifo();
    rx_ready = 1'b0;
    fork
      xfer(1'b0, 10);
      begin
        repeat (1200) @(negedge mclk);
        check(scl_oe_n, 1'b0);
        rx_ready = 1'b1;
      end
    join
    check(8'(got_q.size()), 8'h0a);
    check(got_q[9], 8'h63);
  endtask : s_fifo

  initial begin
    {mclk, arst_n, lowbat, sec_evt, ackr, respr, pdr, tia, rf} = '0;
    rx_ready = 1'b1;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    check({att_n, awake, rx_valid, scl_oe_n, sda_oe_n}, 8'h1b);
    check({scl_out, sda_out}, 8'h00);
    s_normal();
    s_req_awake();
    s_sleep();
    s_lowbat();
    s_target();
    s_fifo();
    wrap_up();
  end
endmodule : testbench
